//--- srbg_pkg.sv
// constants and types shared by the serial rate generator files
package srbg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RX_CTRL = 8'h18;
  localparam logic [7:0] IDX_TX_CTRL = 8'h98;
  localparam logic [7:0] IDX_DIVISOR = 8'h99;
  localparam logic [7:0] IDX_GEN_STAT = 8'h9A;
  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE_BIT = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_CLOCKED_MODE = 4;
  localparam int TX_HIGH_SPEED_SELECT = 2;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam logic [REG_W-1:0] TX_CTRL_RESET = 8'h02;
  localparam logic [REG_W-1:0] TX_CTRL_WR_MASK = 8'hF5;
  // receive_status_control fields
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_STAT_LSB = 0;
  localparam int RX_STAT_W = 3;
  localparam logic [REG_W-1:0] RX_CTRL_RESET = 8'h00;
  localparam logic [REG_W-1:0] RX_CTRL_WR_MASK = 8'hF8;
  localparam logic [REG_W-1:0] DIVISOR_RESET = 8'h00;
  // generator status fields
  localparam int GS_LEVEL = 8;
  localparam int GS_MODE_LSB = 9;
  localparam int GS_PHASE_LSB = 16;
  // rate figures
  localparam int SYNC_PRESCALE = 4;
  localparam int OVS_LOW = 64;
  localparam int OVS_HIGH = 16;
  localparam int PRESC_W = 2;
  localparam int PHASE_W = 6;
  localparam int VOTE_SAMPLES = 3;

  typedef enum logic [1:0] {
    SRBG_ASYNC_LOW = 2'b00,
    SRBG_ASYNC_HIGH = 2'b01,
    SRBG_SYNC_MASTER = 2'b10,
    SRBG_SYNC_SLAVE = 2'b11
  } srbg_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } srbg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } srbg_apb_rsp_t;

  typedef struct packed {
    logic sample;
    logic shift;
  } srbg_ticks_t;
endpackage : srbg_pkg

//--- srbg_props.sv
// port assertions for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module srbg_props #(
  parameter int OVS_LO = 64,
  parameter int OVS_HI = 16,
  parameter int PRESCALE = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire srbg_pkg::srbg_apb_req_t apb_req,
  input wire srbg_pkg::srbg_apb_rsp_t apb_rsp,
  input wire logic ext_shift_clk_pin,
  input wire srbg_pkg::srbg_ticks_t ticks,
  input wire logic [7:0] tx_ctrl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] div_ff;
  logic [7:0] tx_ff;
  logic [15:0] g_ff;
  logic [15:0] h_ff;
  logic [15:0] s_ff;
  logic ok_ff;
  logic sok_ff;
  logic fw_ff;
  wire dw = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready
    & (apb_req.paddr == 12'h264);
  // any config change voids the spacing being measured
  wire chg = dw | (tx_ctrl != tx_ff);
  wire slave = tx_ctrl[4] & ~tx_ctrl[7];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff <= 8'h00;
      tx_ff <= 8'h02;
      g_ff <= 16'h0000;
      h_ff <= 16'h0000;
      s_ff <= 16'h0000;
      ok_ff <= 1'b0;
      sok_ff <= 1'b0;
      fw_ff <= 1'b0;
    end
    else
    begin
      div_ff <= dw ? apb_req.pwdata[7:0] : div_ff;
      tx_ff <= tx_ctrl;
      g_ff <= (ticks.sample | dw) ? {15'h0000, ~dw} : g_ff + 16'h0001;
      h_ff <= ticks.shift ? 16'h0001 : h_ff + 16'h0001;
      s_ff <= ticks.shift ? 16'h0000 : s_ff + {15'h0000, ticks.sample};
      ok_ff <= ~chg & (ok_ff | ticks.sample);
      sok_ff <= ~chg & (sok_ff | ticks.shift);
      // a mode change lets the old count run on, so the first-tick bound no longer applies
      fw_ff <= dw | (fw_ff & ~ticks.sample & (tx_ctrl == tx_ff));
    end
  end
  a_ready_next: assert property (apb_req.psel & ~apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_sample_gap: assert property (
    ticks.sample && ok_ff |-> g_ff == {8'h00, div_ff} + 16'h0001)
    else $error("sample spacing wrong");
  a_first_tick: assert property (
    ticks.sample && fw_ff |-> g_ff <= {8'h00, div_ff} + 16'h0001)
    else $error("late first tick after divisor write");
  a_shift_ratio: assert property (
    ticks.shift && sok_ff && !tx_ctrl[4]
    |-> s_ff + {15'h0000, ticks.sample} == (tx_ctrl[2] ? OVS_HI : OVS_LO))
    else $error("async shift ratio wrong");
  a_sync_gap: assert property (
    ticks.shift && sok_ff && tx_ctrl[4] && tx_ctrl[7]
    |-> h_ff == PRESCALE * ({8'h00, div_ff} + 16'h0001))
    else $error("sync shift spacing wrong");
  a_sync_quiet: assert property (tx_ctrl[4] && $past(tx_ctrl[4], 2) |-> !ticks.sample)
    else $error("sample tick in sync mode");
  a_slave_edge: assert property ($rose(ext_shift_clk_pin) && slave |-> ##[2:4] ticks.shift)
    else $error("no shift after external clock edge");
  c_async: cover property (ticks.shift && sok_ff && !tx_ctrl[4]);
  c_master: cover property (ticks.shift && sok_ff && tx_ctrl[4]);
  c_slave: cover property (slave && ticks.shift);
endmodule : srbg_props
bind srbg_top srbg_props #(.OVS_LO(OVS_LO), .OVS_HI(OVS_HI), .PRESCALE(PRESCALE)) u_srbg_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ext_shift_clk_pin(ext_shift_clk_pin), .ticks(ticks), .tx_ctrl(tx_ctrl));
`default_nettype wire

//--- srbg_remote.sv
// remote serial device driving the receive line and external shift clock
`timescale 1ns/1ps
`default_nettype none
module srbg_remote (
  input wire logic pclk,
  output logic rx_pin,
  output logic sck_pin
);
  // line idles high, clock stands low outside frames
  initial
  begin
    rx_pin = 1'b1;
    sck_pin = 1'b0;
  end
  task hold(input logic v, input int cyc);
    @(posedge pclk);
    rx_pin <= v;
    repeat (cyc) @(posedge pclk);
  endtask : hold
  task pulses(input int cnt);
    repeat (cnt)
    begin
      @(posedge pclk);
      sck_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      sck_pin <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : pulses
endmodule : srbg_remote
`default_nettype wire

//--- srbg_top.sv
// serial rate generator: apb registers, divisor timer, rx majority vote
//
// Notes on behaviour
// RQ1: free-running 8-bit timer, period from divisor
// RQ2: high-speed select changes async rate
// RQ3: synchronous mode ignores high-speed select
// RQ4: async low speed: fosc/(64(x+1))
// RQ5: async high speed: fosc/(16(x+1))
// RQ6: synchronous: fosc/(4(x+1)), no fast variant
// RQ7: any divisor 0 to 255 accepted
// RQ8: divisor rate only as internal-clock master
// RQ9: divisor write clears the timer at once
// RQ10: three samples per bit, majority decides
// RQ11: software may prefer fast divider for accuracy
// RQ12: clocked-mode bit picks async or sync
// RQ13: async sample tick 16x or 64x bit rate
// RQ14: reload at terminal count, tick every x+1
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module srbg_top #(
  parameter int DIV_W = 8,
  parameter int OVS_LO = srbg_pkg::OVS_LOW,
  parameter int OVS_HI = srbg_pkg::OVS_HIGH,
  parameter int PRESCALE = srbg_pkg::SYNC_PRESCALE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire srbg_pkg::srbg_apb_req_t apb_req,
  output srbg_pkg::srbg_apb_rsp_t apb_rsp,
  input wire logic receive_data_pin,
  input wire logic ext_shift_clk_pin,
  input wire logic tx_shift_empty,
  input wire logic [srbg_pkg::RX_STAT_W-1:0] rx_status,
  output srbg_pkg::srbg_ticks_t ticks,
  output logic rx_level,
  output logic [srbg_pkg::REG_W-1:0] tx_ctrl,
  output logic [srbg_pkg::REG_W-1:0] rx_ctrl
);
  localparam logic [srbg_pkg::PRESC_W-1:0] PRESC_LAST =
    srbg_pkg::PRESC_W'(PRESCALE - 1);
  localparam logic [srbg_pkg::PHASE_W-1:0] PH_LAST_LO =
    srbg_pkg::PHASE_W'(OVS_LO - 1);
  localparam logic [srbg_pkg::PHASE_W-1:0] PH_LAST_HI =
    srbg_pkg::PHASE_W'(OVS_HI - 1);
  localparam logic [srbg_pkg::PHASE_W-1:0] PH_MID_LO =
    srbg_pkg::PHASE_W'(OVS_LO / 2);
  localparam logic [srbg_pkg::PHASE_W-1:0] PH_MID_HI =
    srbg_pkg::PHASE_W'(OVS_HI / 2);
  localparam logic [srbg_pkg::PHASE_W-1:0] PH_ONE =
    srbg_pkg::PHASE_W'(1);

  // byte address of a register index
  function automatic logic [srbg_pkg::ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

  // masked write of one byte register
  function automatic logic [srbg_pkg::REG_W-1:0] mask_wr(
    input logic [srbg_pkg::REG_W-1:0] old_v,
    input logic [srbg_pkg::REG_W-1:0] new_v,
    input logic [srbg_pkg::REG_W-1:0] mask
  );
    mask_wr = (old_v & ~mask) | (new_v & mask);
  endfunction : mask_wr

  // apb response state
  logic pready_ff;
  logic pslverr_ff;
  logic [srbg_pkg::DATA_W-1:0] prdata_ff;
  logic nxt_pready;
  logic nxt_pslverr;
  logic [srbg_pkg::DATA_W-1:0] nxt_prdata;

  // software registers
  logic [srbg_pkg::REG_W-1:0] tx_ctrl_ff;
  logic [srbg_pkg::REG_W-1:0] rx_ctrl_ff;
  logic [DIV_W-1:0] divisor_ff;
  logic [srbg_pkg::REG_W-1:0] nxt_tx_ctrl;
  logic [srbg_pkg::REG_W-1:0] nxt_rx_ctrl;
  logic [DIV_W-1:0] nxt_divisor;

  // generator state
  logic [srbg_pkg::PRESC_W-1:0] presc_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic [srbg_pkg::PHASE_W-1:0] phase_ff;
  logic sample_tick_ff;
  logic shift_tick_ff;
  logic [srbg_pkg::PRESC_W-1:0] nxt_presc;
  logic [DIV_W-1:0] nxt_cnt;
  logic [srbg_pkg::PHASE_W-1:0] nxt_phase;
  logic nxt_sample_tick;
  logic nxt_shift_tick;

  // pin synchronisers
  logic rxd_s1_ff;
  logic rxd_s2_ff;
  logic eclk_s1_ff;
  logic eclk_s2_ff;
  logic eclk_s3_ff;

  // decode
  wire logic setup_phase;
  wire logic access_done;
  wire logic wr_done;
  wire logic hit_rx_ctrl;
  wire logic hit_tx_ctrl;
  wire logic hit_divisor;
  wire logic hit_gen_stat;
  wire logic hit_any;
  wire logic [srbg_pkg::REG_W-1:0] wr_byte;
  wire logic divisor_wr;
  wire logic [srbg_pkg::DATA_W-1:0] rd_word;
  wire logic [srbg_pkg::DATA_W-1:0] gen_stat_word;
  wire logic [srbg_pkg::REG_W-1:0] tx_ctrl_view;
  wire logic [srbg_pkg::REG_W-1:0] rx_ctrl_view;

  // mode and timing
  srbg_pkg::srbg_mode_t mode;
  wire logic clocked_mode;
  wire logic high_speed_select;
  wire logic clock_source_select;
  wire logic presc_done;
  wire logic base_tick;
  wire logic [srbg_pkg::PHASE_W-1:0] phase_last;
  wire logic [srbg_pkg::PHASE_W-1:0] phase_mid;
  wire logic phase_wrap;
  wire logic mid_window;
  wire logic ext_rise;
  wire logic vote_take;
  wire logic voted_level;

  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready_ff;
  assign wr_done = access_done & apb_req.pwrite;
  assign hit_rx_ctrl = apb_req.paddr == reg_addr(srbg_pkg::IDX_RX_CTRL);
  assign hit_tx_ctrl = apb_req.paddr == reg_addr(srbg_pkg::IDX_TX_CTRL);
  assign hit_divisor = apb_req.paddr == reg_addr(srbg_pkg::IDX_DIVISOR);
  assign hit_gen_stat = apb_req.paddr == reg_addr(srbg_pkg::IDX_GEN_STAT);
  assign hit_any = hit_rx_ctrl | hit_tx_ctrl | hit_divisor | hit_gen_stat;
  assign wr_byte = apb_req.pwdata[srbg_pkg::REG_W-1:0];
  assign divisor_wr = wr_done & hit_divisor;

  // shift-empty and receive flags belong to the shifters, shown live here
  assign tx_ctrl_view = {tx_ctrl_ff[srbg_pkg::REG_W-1:srbg_pkg::TX_SHIFT_EMPTY+1],
                         tx_shift_empty,
                         tx_ctrl_ff[srbg_pkg::TX_SHIFT_EMPTY-1:0]};
  assign rx_ctrl_view = {rx_ctrl_ff[srbg_pkg::REG_W-1:srbg_pkg::RX_STAT_W],
                         rx_status};

  assign gen_stat_word = {{(srbg_pkg::DATA_W-srbg_pkg::GS_PHASE_LSB-srbg_pkg::PHASE_W){1'b0}},
                          phase_ff,
                          {(srbg_pkg::GS_PHASE_LSB-srbg_pkg::GS_MODE_LSB-2){1'b0}},
                          mode,
                          voted_level,
                          {(srbg_pkg::GS_LEVEL-DIV_W){1'b0}},
                          cnt_ff};

  assign rd_word = hit_rx_ctrl ? {{(srbg_pkg::DATA_W-srbg_pkg::REG_W){1'b0}}, rx_ctrl_view} :
                   hit_tx_ctrl ? {{(srbg_pkg::DATA_W-srbg_pkg::REG_W){1'b0}}, tx_ctrl_view} :
                   hit_divisor ? {{(srbg_pkg::DATA_W-DIV_W){1'b0}}, divisor_ff} :
                   hit_gen_stat ? gen_stat_word :
                   '0;

  // one wait-free access phase: ready rises on the cycle after setup
  assign nxt_pready = setup_phase;
  assign nxt_pslverr = setup_phase & ~hit_any;
  assign nxt_prdata = setup_phase ? rd_word : prdata_ff;

  assign nxt_tx_ctrl = (wr_done & hit_tx_ctrl) ?
                       mask_wr(tx_ctrl_ff, wr_byte, srbg_pkg::TX_CTRL_WR_MASK) :
                       tx_ctrl_ff;
  assign nxt_rx_ctrl = (wr_done & hit_rx_ctrl) ?
                       mask_wr(rx_ctrl_ff, wr_byte, srbg_pkg::RX_CTRL_WR_MASK) :
                       rx_ctrl_ff;
  // every value 0..255 is legal, zero gives the fastest rate
  assign nxt_divisor = divisor_wr ? wr_byte[DIV_W-1:0] : divisor_ff; // RQ7

  assign clocked_mode = tx_ctrl_ff[srbg_pkg::TX_CLOCKED_MODE];
  assign high_speed_select = tx_ctrl_ff[srbg_pkg::TX_HIGH_SPEED_SELECT];
  assign clock_source_select = tx_ctrl_ff[srbg_pkg::TX_CLOCK_SOURCE_SELECT];

  always_comb
  begin
    if (!clocked_mode) // RQ12
    begin
      mode = high_speed_select ? srbg_pkg::SRBG_ASYNC_HIGH : srbg_pkg::SRBG_ASYNC_LOW; // RQ2
    end
    else
    begin
      // the speed bit is not consulted at all here
      mode = clock_source_select ? srbg_pkg::SRBG_SYNC_MASTER : srbg_pkg::SRBG_SYNC_SLAVE; // RQ3
    end
  end

  // async counts at the oscillator, sync through a divide-by-four prescaler
  assign presc_done = clocked_mode ? (presc_ff == PRESC_LAST) : 1'b1; // RQ6
  assign base_tick = presc_done & (cnt_ff == divisor_ff); // RQ14

  assign phase_last = high_speed_select ? PH_LAST_HI : PH_LAST_LO; // RQ13
  assign phase_mid = high_speed_select ? PH_MID_HI : PH_MID_LO;
  assign phase_wrap = phase_ff == phase_last;
  assign mid_window = (phase_ff == phase_mid - PH_ONE) |
                      (phase_ff == phase_mid) |
                      (phase_ff == phase_mid + PH_ONE);

  assign ext_rise = eclk_s2_ff & ~eclk_s3_ff;

  always_comb
  begin
    nxt_presc = presc_done ? '0 : presc_ff + srbg_pkg::PRESC_W'(1);
    nxt_cnt = base_tick ? '0 : (presc_done ? cnt_ff + DIV_W'(1) : cnt_ff); // RQ1
    nxt_phase = phase_ff;
    nxt_sample_tick = 1'b0;
    nxt_shift_tick = 1'b0;
    unique case (mode)
      srbg_pkg::SRBG_ASYNC_LOW,
      srbg_pkg::SRBG_ASYNC_HIGH:
      begin
        if (base_tick)
        begin
          nxt_sample_tick = 1'b1; // RQ13
          nxt_phase = phase_wrap ? '0 : phase_ff + PH_ONE;
          nxt_shift_tick = phase_wrap; // RQ4 RQ5
        end
      end
      srbg_pkg::SRBG_SYNC_MASTER:
      begin
        nxt_phase = '0;
        nxt_shift_tick = base_tick; // RQ6 RQ8
      end
      srbg_pkg::SRBG_SYNC_SLAVE:
      begin
        // outside clock paces the shifter; the divisor is not used
        nxt_phase = '0;
        nxt_shift_tick = ext_rise; // RQ8
      end
    endcase
    // a new divisor restarts the period from zero
    if (divisor_wr) // RQ9
    begin
      nxt_presc = '0;
      nxt_cnt = '0;
      nxt_phase = '0;
    end
  end

  // async votes on three sample ticks around mid-bit; sync on three clocks
  assign vote_take = clocked_mode ? 1'b1 : (base_tick & mid_window); // RQ10

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ctrl_ff <= srbg_pkg::TX_CTRL_RESET;
      rx_ctrl_ff <= srbg_pkg::RX_CTRL_RESET;
      divisor_ff <= DIV_W'(srbg_pkg::DIVISOR_RESET);
    end
    else
    begin
      tx_ctrl_ff <= nxt_tx_ctrl;
      rx_ctrl_ff <= nxt_rx_ctrl;
      divisor_ff <= nxt_divisor;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_ff <= '0;
      cnt_ff <= '0;
      phase_ff <= '0;
      sample_tick_ff <= 1'b0;
      shift_tick_ff <= 1'b0;
    end
    else
    begin
      presc_ff <= nxt_presc;
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
      sample_tick_ff <= nxt_sample_tick;
      shift_tick_ff <= nxt_shift_tick;
    end
  end

  // both pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      eclk_s1_ff <= 1'b0;
      eclk_s2_ff <= 1'b0;
      eclk_s3_ff <= 1'b0;
    end
    else
    begin
      rxd_s1_ff <= receive_data_pin;
      rxd_s2_ff <= rxd_s1_ff;
      eclk_s1_ff <= ext_shift_clk_pin;
      eclk_s2_ff <= eclk_s1_ff;
      eclk_s3_ff <= eclk_s2_ff;
    end
  end

  srbg_vote u_vote (
    .pclk(pclk),
    .presetn(presetn),
    .take(vote_take),
    .din(rxd_s2_ff),
    .level(voted_level)
  );

  assign apb_rsp.pready = pready_ff;
  assign apb_rsp.pslverr = pslverr_ff;
  assign apb_rsp.prdata = prdata_ff;
  assign ticks.sample = sample_tick_ff;
  assign ticks.shift = shift_tick_ff;
  assign rx_level = voted_level;
  assign tx_ctrl = tx_ctrl_ff;
  assign rx_ctrl = rx_ctrl_ff;
endmodule : srbg_top
`default_nettype wire

//--- srbg_vote.sv
// three-sample majority decision on the receive line
`timescale 1ns/1ps
`default_nettype none
module srbg_vote (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic take,
  input wire logic din,
  output logic level
);
  logic [srbg_pkg::VOTE_SAMPLES-1:0] samp_ff;
  logic level_ff;
  logic [srbg_pkg::VOTE_SAMPLES-1:0] nxt_samp;
  logic nxt_level;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  assign nxt_samp = {samp_ff[srbg_pkg::VOTE_SAMPLES-2:0], din};
  // the level only moves when a sample is taken, so one glitch cannot flip it
  assign nxt_level = take ? maj3(nxt_samp) : level_ff; // RQ10

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_ff <= '1;
      level_ff <= 1'b1;
    end
    else
    begin
      if (take)
      begin
        samp_ff <= nxt_samp;
      end
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
endmodule : srbg_vote
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  srbg_pkg::srbg_apb_req_t req = '0;
  srbg_pkg::srbg_apb_rsp_t rsp;
  srbg_pkg::srbg_ticks_t ticks;
  logic rx_pin;
  logic sck_pin;
  logic rx_level;
  logic tx_empty = 1'b1;
  logic [2:0] rx_st = 3'h5;
  logic [7:0] tx_ctrl;
  logic [7:0] rx_ctrl;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checked = 0;
  int n;
  int i;
  // mode, divisor, tick kind, expected cycles between ticks
  logic [7:0] md [8] = '{8'h04, 8'h04, 8'h00, 8'h04, 8'h04, 8'h90, 8'h94, 8'h00};
  logic [7:0] dv [8] = '{8'h03, 8'h03, 8'h03, 8'hFF, 8'h00, 8'h03, 8'h03, 8'h00};
  logic sh [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  int want [8] = '{4, 64, 256, 4096, 16, 16, 16, 64};
  always #20 pclk = ~pclk;
  srbg_top u_srbg_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .receive_data_pin(rx_pin), .ext_shift_clk_pin(sck_pin), .tx_shift_empty(tx_empty),
    .rx_status(rx_st), .ticks(ticks), .rx_level(rx_level), .tx_ctrl(tx_ctrl),
    .rx_ctrl(rx_ctrl));
  srbg_remote u_srbg_remote (.pclk(pclk), .rx_pin(rx_pin), .sck_pin(sck_pin));
  task test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task cmp(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    // read right after the edge, so the values are those the edge sampled
    do
    begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    cmp(32'h0000_0001, {31'h0000_0000, rsp.pready});
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // divisor written last so the phase restarts under the new mode
  task cfg(input logic [7:0] m, input logic [7:0] d);
    apb(1'b1, 12'h260, {24'h00_0000, m});
    apb(1'b1, 12'h264, {24'h00_0000, d});
  endtask : cfg
  task gap(input logic shf, output int cyc);
    int k;
    for (k = 0; k < 2; k++)
    begin
      cyc = 0;
      do
      begin
        @(posedge pclk);
        #1;
        cyc++;
      end while (((shf ? ticks.shift : ticks.sample) !== 1'b1) && cyc < 9000);
    end
  endtask : gap
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h060, 32'h0000_0000);
    cmp(32'h0000_0005, rd);
    apb(1'b0, 12'h260, 32'h0000_0000);
    cmp(32'h0000_0002, rd);
    apb(1'b0, 12'h264, 32'h0000_0000);
    cmp(32'h0000_0000, rd);
    cmp(32'h0000_0000, {31'h0000_0000, err});
    apb(1'b1, 12'h060, 32'hFFFF_FFFF);
    apb(1'b0, 12'h060, 32'h0000_0000);
    cmp(32'h0000_00FD, rd);
    cmp(32'h0000_00F8, {24'h00_0000, rx_ctrl});
    apb(1'b1, 12'h260, 32'h0000_00FF);
    apb(1'b0, 12'h260, 32'h0000_0000);
    cmp(32'h0000_00F7, rd);
    cmp(32'h0000_00F7, {24'h00_0000, tx_ctrl});
    apb(1'b0, 12'h100, 32'h0000_0000);
    cmp(32'h0000_0000, rd);
    cmp(32'h0000_0001, {31'h0000_0000, err});
    // mostly the fast divider, as it gives the finer rate steps
    for (i = 0; i < 8; i++)
    begin
      cfg(md[i], dv[i]);
      gap(sh[i], n);
      cmp(want[i], n);
    end
    cfg(8'h10, 8'h00);
    n = 0;
    fork
      u_srbg_remote.pulses(5);
      repeat (80)
      begin
        @(posedge pclk);
        #1;
        if (ticks.shift === 1'b1)
          n++;
      end
    join
    cmp(5, n);
    cfg(8'h04, 8'h03);
    u_srbg_remote.hold(1'b0, 300);
    cmp(32'h0000_0000, {31'h0000_0000, rx_level});
    apb(1'b0, 12'h268, 32'h0000_0000);
    cmp(32'h0000_0200, rd & 32'h0000_0700);
    u_srbg_remote.hold(1'b1, 300);
    cmp(32'h0000_0001, {31'h0000_0000, rx_level});
    n = 0;
    // a short glitch can reach only one of the three takes
    fork
      begin
        u_srbg_remote.hold(1'b0, 1);
        u_srbg_remote.hold(1'b1, 1);
      end
      repeat (200)
      begin
        @(posedge pclk);
        #1;
        if (rx_level !== 1'b1)
          n++;
      end
    join
    cmp(0, n);
    test_done;
  end
  initial
  begin
    #2_000_000;
    error_cnt++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
